// ===== inc/tes_pkg.sv
/*
  tes_pkg: constants shared by the translation buffer sideband block.
  register offsets, field positions, reset values and the self-test
  handshake states. assumes a 32-bit apb register bus.
*/
package tes_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] AUX_CFG_OFS  = 12'h000;
  localparam logic [11:0] STATUS_OFS   = 12'h004;
  localparam logic [11:0] TICK_CNT_OFS = 12'h008;
  localparam logic [11:0] EV_TOTAL_OFS = 12'h00c;

  // ---------------------------------------------------------------
  // auxiliary_config_register fields
  // ---------------------------------------------------------------
  localparam int AUX_NORM_BIT  = 0;
  localparam int AUX_EVEN_BIT  = 1;
  localparam logic AUX_EVEN_RST = 1'h1;

  // ---------------------------------------------------------------
  // status register fields
  // ---------------------------------------------------------------
  localparam int ST_CTTW_BIT   = 0;
  localparam int ST_TEST_BIT   = 1;
  localparam int ST_SECEN_BIT  = 2;
  localparam int ST_BIST_BIT   = 3;
  localparam int ST_READY_BIT  = 4;

  // ---------------------------------------------------------------
  // timing and sizes
  // ---------------------------------------------------------------
  localparam int TICK_DIV_W     = 6;
  localparam logic [5:0] TICK_WRAP = 6'h3f;
  localparam int BIST_DATA_W    = 52;
  localparam int BIST_HOLD      = 3;
  localparam int BUF_DEPTH      = 16;
  localparam logic [1:0] INIT_DONE = 2'h2;

  // ---------------------------------------------------------------
  // self-test handshake states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TES_BIST_IDLE,
    TES_BIST_ACK,
    TES_BIST_DROP
  } tes_bist_st_t;

endpackage : tes_pkg

// ===== core/tes_buf_mem.sv
/*
  tes_buf_mem: the translation buffer storage, one port, registered
  read data. assumes one clock and an owner that never reads and
  writes the same cycle; read data stay until the next read.
*/
`timescale 1ns/10ps
module tes_buf_mem #(
  parameter int WIDTH = tes_pkg::BIST_DATA_W,
  parameter int DEPTH = tes_pkg::BUF_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // access port
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    addr,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rdata;
  } tes_mem_state_t;

  tes_mem_state_t s_q;
  tes_mem_state_t s_d;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.mem[addr] = wdata;
    end
    // read data held in a register until the next read
    if (rd_en) begin
      s_d.rdata = s_q.mem[addr];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;

endmodule : tes_buf_mem

// ===== core/tes_sideband.sv
/*
  tes_sideband: performance events, secure gating, tie-off capture and
  the memory self-test port of the translation buffer block.
  assumes the access and refill strobes come from logic on pclk, the
  self-test controller runs on pclk, and the tie-offs and the debug
  enable are pins from outside the clock domain.

*/
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
module tes_sideband #(
  parameter int BUF_DEPTH = tes_pkg::BUF_DEPTH,
  parameter int BIST_W    = tes_pkg::BIST_DATA_W,
  parameter int buffer_row_index_width = $clog2(BUF_DEPTH)
) (
  // clock and reset
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // apb slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [31:0]                       paddr,
  input  wire logic [31:0]                       pwdata,
  input  wire logic [3:0]                        pstrb,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // transaction strobes from the translation logic
  input  wire logic                              rd_access,
  input  wire logic                              rd_access_secure,
  input  wire logic                              wr_access,
  input  wire logic                              wr_access_secure,
  input  wire logic                              rd_refill,
  input  wire logic                              rd_refill_secure,
  input  wire logic                              wr_refill,
  input  wire logic                              wr_refill_secure,
  // authentication and tie-off pins
  input  wire logic                              secure_count_en,
  input  wire logic                              coherent_walk_tie,
  input  wire logic                              test_mode,
  input  wire logic                              normalize_tie,
  // levels handed on to the rest of the block; coherent_walk static, normalize_attr writable, test_mode_active follows the pin
  output logic                                   coherent_walk,
  output logic                                   test_mode_active,
  output logic                                   normalize_attr,
  // memory self-test port
  input  wire logic                              bist_req,
  output logic                                   bist_ack,
  input  wire logic [buffer_row_index_width-1:0] bist_addr,
  input  wire logic                              bist_rd_en,
  input  wire logic                              bist_wr_en,
  input  wire logic [BIST_W-1:0]                 bist_wdata,
  output logic      [BIST_W-1:0]                 bist_rdata,
  // performance events
  output logic                                   tick_event,
  output logic                                   tick_div_event,
  output logic                                   wr_access_event,
  output logic                                   rd_access_event,
  output logic                                   wr_refill_event,
  output logic                                   rd_refill_event
);

  typedef struct packed {
    // pin synchronisers, first and second stage
    logic [3:0]               pin_s1;
    logic [3:0]               pin_s2;
    logic [1:0]               init_cnt;
    logic                     ready;
    logic                     cttw;
    logic                     norm;
    logic                     ev_en;
    logic [5:0]               div_cnt;
    logic [31:0]              ev_total;
    tes_pkg::tes_bist_st_t    bist_st;
    logic                     ack;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic                     ev_tick;
    logic                     ev_div;
    logic                     ev_wa;
    logic                     ev_ra;
    logic                     ev_wf;
    logic                     ev_rf;
  } tes_state_t;

  tes_state_t s_q;
  tes_state_t s_d;

  // synchronised pin levels: order is secure, cttw, test, normalize
  logic sec_en_s;
  logic cttw_s;
  logic test_s;
  logic norm_s;

  assign sec_en_s = s_q.pin_s2[3];
  assign cttw_s   = s_q.pin_s2[2];
  assign test_s   = s_q.pin_s2[1];
  assign norm_s   = s_q.pin_s2[0];

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // one event passes unless it is secure and secure counting is off
  function automatic logic tes_gate(input logic valid, input logic secure,
                                    input logic sec_en);
    tes_gate = valid && (!secure || sec_en);
  endfunction : tes_gate

  function automatic logic tes_hit(input logic [31:0] addr, input logic [11:0] ofs);
    tes_hit = (addr[31:12] == 20'h00000) && (addr[11:0] == ofs);
  endfunction : tes_hit

  // ---------------------------------------------------------------
  // storage for self-test
  // ---------------------------------------------------------------
  logic                  mem_wr;
  logic                  mem_rd;
  logic [BIST_W-1:0]     mem_rdata;

  // storage only moves while the self-test owns it
  assign mem_wr = s_q.ack && bist_wr_en;
  assign mem_rd = s_q.ack && bist_rd_en && !bist_wr_en;

  tes_buf_mem #(
    .WIDTH (BIST_W),
    .DEPTH (BUF_DEPTH),
    .AW    (buffer_row_index_width)
  ) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (mem_wr),
    .rd_en   (mem_rd),
    .addr    (bist_addr),
    .wdata   (bist_wdata),
    .rdata   (mem_rdata)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic        wa;
  logic        ra;
  logic        wf;
  logic        rf;
  logic        ev_on;
  logic        setup;
  logic        access;
  logic        hit_any;
  logic [31:0] rd_word;
  logic [2:0]  ev_sum;

  always_comb begin
    s_d     = s_q;
    wa      = 1'b0;
    ra      = 1'b0;
    wf      = 1'b0;
    rf      = 1'b0;
    ev_on   = 1'b0;
    setup   = 1'b0;
    access  = 1'b0;
    hit_any = 1'b0;
    rd_word = 32'h00000000;
    ev_sum  = 3'h0;

    // pins pass two flops before anything reads them
    s_d.pin_s1 = {secure_count_en, coherent_walk_tie, test_mode, normalize_tie};
    s_d.pin_s2 = s_q.pin_s1;

    // capture of the tie-offs once the synchronisers are filled
    if (!s_q.ready) begin
      if (s_q.init_cnt == tes_pkg::INIT_DONE) begin
        s_d.ready = 1'b1;
        s_d.cttw  = cttw_s;
        s_d.norm  = norm_s;
      end else begin
        s_d.init_cnt = s_q.init_cnt + 2'h1;
      end
    end

    // free-running divider, pulse on wrap
    s_d.div_cnt = s_q.div_cnt + 6'h01;

    // events are held low in test mode and until capture is done
    ev_on = s_q.ready && s_q.ev_en && !test_s;
    wa = ev_on && tes_gate(wr_access, wr_access_secure, sec_en_s);
    ra = ev_on && tes_gate(rd_access, rd_access_secure, sec_en_s);
    wf = ev_on && tes_gate(wr_refill, wr_refill_secure, sec_en_s);
    rf = ev_on && tes_gate(rd_refill, rd_refill_secure, sec_en_s);

    s_d.ev_tick = ev_on;
    s_d.ev_div  = ev_on && (s_q.div_cnt == tes_pkg::TICK_WRAP);
    s_d.ev_wa   = wa;
    s_d.ev_ra   = ra;
    s_d.ev_wf   = wf;
    s_d.ev_rf   = rf;
    // one flop per strobe gives one pulse per accepted cycle
    ev_sum = 3'({2'h0, wa} + {2'h0, ra} + {2'h0, wf} + {2'h0, rf});
    s_d.ev_total = s_q.ev_total + {29'h0, ev_sum};

    // self-test handshake
    unique case (s_q.bist_st)
      tes_pkg::TES_BIST_IDLE: begin
        if (bist_req && s_q.ready) begin
          s_d.bist_st = tes_pkg::TES_BIST_ACK;
          s_d.ack     = 1'b1;
        end
      end
      tes_pkg::TES_BIST_ACK: begin
        if (!bist_req) begin
          s_d.bist_st = tes_pkg::TES_BIST_DROP;
          s_d.ack     = 1'b0;
        end
      end
      tes_pkg::TES_BIST_DROP: begin
        s_d.bist_st = tes_pkg::TES_BIST_IDLE;
      end
      default: begin
        s_d.bist_st = tes_pkg::TES_BIST_IDLE;
        s_d.ack     = 1'b0;
      end
    endcase

    // apb slave: no wait state, answer prepared in the setup cycle
    setup  = psel && !penable;
    access = psel && penable && s_q.pready;
    hit_any = tes_hit(paddr, tes_pkg::AUX_CFG_OFS) || tes_hit(paddr, tes_pkg::STATUS_OFS)
           || tes_hit(paddr, tes_pkg::TICK_CNT_OFS) || tes_hit(paddr, tes_pkg::EV_TOTAL_OFS);
    if (tes_hit(paddr, tes_pkg::AUX_CFG_OFS)) begin
      rd_word[tes_pkg::AUX_NORM_BIT] = s_q.norm;
      rd_word[tes_pkg::AUX_EVEN_BIT] = s_q.ev_en;
    end else if (tes_hit(paddr, tes_pkg::STATUS_OFS)) begin
      rd_word[tes_pkg::ST_CTTW_BIT]  = s_q.cttw;
      rd_word[tes_pkg::ST_TEST_BIT]  = test_s;
      rd_word[tes_pkg::ST_SECEN_BIT] = sec_en_s;
      rd_word[tes_pkg::ST_BIST_BIT]  = s_q.ack;
      rd_word[tes_pkg::ST_READY_BIT] = s_q.ready;
    end else if (tes_hit(paddr, tes_pkg::TICK_CNT_OFS)) begin
      rd_word[tes_pkg::TICK_DIV_W-1:0] = s_q.div_cnt;
    end else if (tes_hit(paddr, tes_pkg::EV_TOTAL_OFS)) begin
      rd_word = s_q.ev_total;
    end

    if (setup) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !hit_any;
      s_d.prdata  = (pwrite || !hit_any) ? 32'h00000000 : rd_word;
    end else begin
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
    end

    // writes land at the completing edge; byte lane 0 holds the fields
    if (access && pwrite && pstrb[0]) begin
      if (tes_hit(paddr, tes_pkg::AUX_CFG_OFS)) begin
        s_d.norm  = pwdata[tes_pkg::AUX_NORM_BIT];
        s_d.ev_en = pwdata[tes_pkg::AUX_EVEN_BIT];
      end else if (tes_hit(paddr, tes_pkg::EV_TOTAL_OFS)) begin
        s_d.ev_total = 32'h00000000;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q         <= '0;
      s_q.ev_en   <= tes_pkg::AUX_EVEN_RST;
      s_q.bist_st <= tes_pkg::TES_BIST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata           = s_q.prdata;
  assign pready           = s_q.pready;
  assign pslverr          = s_q.pslverr;
  assign coherent_walk    = s_q.cttw;
  assign test_mode_active = s_q.pin_s2[1];
  assign normalize_attr   = s_q.norm;
  assign bist_ack         = s_q.ack;
  assign bist_rdata       = mem_rdata;
  assign tick_event       = s_q.ev_tick;
  assign tick_div_event   = s_q.ev_div;
  assign wr_access_event  = s_q.ev_wa;
  assign rd_access_event  = s_q.ev_ra;
  assign wr_refill_event  = s_q.ev_wf;
  assign rd_refill_event  = s_q.ev_rf;

endmodule : tes_sideband

// ===== testbench/tes_sideband_chk.sv
/* checker of the sideband block ports.
   assumes a bind onto tes_sideband and the pclk clock. */
`timescale 1ns/10ps
module tes_sideband_chk (
  // clock, reset, pins
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        rd_access,
  input wire logic        rd_access_secure,
  input wire logic        wr_access,
  input wire logic        rd_refill,
  input wire logic        wr_refill,
  input wire logic        secure_count_en,
  input wire logic        coherent_walk_tie,
  input wire logic        normalize_tie,
  input wire logic        coherent_walk,
  input wire logic        test_mode_active,
  input wire logic        normalize_attr,
  // self-test
  input wire logic        bist_req,
  input wire logic        bist_ack,
  input wire logic        bist_rd_en,
  input wire logic [51:0] bist_rdata,
  // events
  input wire logic        tick_event,
  input wire logic        tick_div_event,
  input wire logic        wr_access_event,
  input wire logic        rd_access_event,
  input wire logic        wr_refill_event,
  input wire logic        rd_refill_event
);
  // ---------------------------------------------------------------
  // cycle counters since reset release
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] div_q;
  logic [2:0] up_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 6'h00;
      up_q  <= 3'h0;
    end else begin
      div_q <= div_q + 6'h01;
      if (up_q != 3'h7) begin
        up_q <= up_q + 3'h1;
      end
    end
  end
  a_norm_load: assert property (up_q == 3'h3 |-> normalize_attr == normalize_tie &&
    coherent_walk == coherent_walk_tie) else $error("tie capture wrong");
  a_walk_static: assert property (up_q == 3'h7 |-> $stable(coherent_walk))
    else $error("coherent walk moved");
  a_div_phase: assert property (tick_div_event |-> div_q == 6'h00)
    else $error("divided event off phase");
  a_tick_with_div: assert property (tick_div_event |-> tick_event)
    else $error("tick missing");
  a_test_gate: assert property (test_mode_active && $past(test_mode_active)
    |-> !tick_event && !rd_access_event) else $error("event in test mode");
  a_sec_gate: assert property (rd_access_event && $past(rd_access_secure)
    |-> $past(secure_count_en, 2) || $past(secure_count_en, 3) || $past(secure_count_en, 4))
    else $error("secure event not gated");
  a_wr_cause: assert property (wr_access_event |-> $past(wr_access))
    else $error("write event without access");
  a_rd_cause: assert property (rd_access_event |-> $past(rd_access))
    else $error("read event without access");
  a_refill_cause: assert property ((wr_refill_event |-> $past(wr_refill)) and
    (rd_refill_event |-> $past(rd_refill))) else $error("refill event without cause");
  a_ack_req: assert property (bist_ack |-> $past(bist_req))
    else $error("ack without request");
  a_ack_hold: assert property (bist_req && bist_ack |=> bist_ack)
    else $error("ack dropped early");
  a_rdata_hold: assert property ($changed(bist_rdata) |-> $past(bist_rd_en && bist_ack))
    else $error("self-test data moved");
  c_div: cover property (tick_div_event);
  c_bist_rd: cover property (bist_ack && bist_rd_en);
  c_sec: cover property (rd_access_event && $past(rd_access_secure));
endmodule : tes_sideband_chk
bind tes_sideband tes_sideband_chk chk_u (.*);

// ===== testbench/tes_bist_model.sv
/* self-test controller model for the buffer storage port.
   assumes pclk and tasks called by the bench. */
`timescale 1ns/10ps
module tes_bist_model #(
  parameter int AW = 4,
  parameter int W  = tes_pkg::BIST_DATA_W
) (
  // clock
  input wire logic         pclk,
  // self-test port
  output logic             bist_req,
  input wire logic         bist_ack,
  output logic [AW-1:0]    bist_addr,
  output logic             bist_rd_en,
  output logic             bist_wr_en,
  output logic [W-1:0]     bist_wdata,
  input wire logic [W-1:0] bist_rdata
);
  // ---------------------------------------------------------------
  // controller tasks; released lines show inverted values
  // ---------------------------------------------------------------
  initial begin
    bist_req = 1'b0;
    bist_rd_en = 1'b0;
    bist_wr_en = 1'b0;
    bist_addr = '0;
    bist_wdata = '0;
  end
  task automatic open();
    int t;
    @(posedge pclk);
    bist_req <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (bist_ack !== 1'b1 && t < 20);
  endtask : open
  task automatic wr(logic [AW-1:0] a, logic [W-1:0] d);
    @(posedge pclk);
    bist_wr_en <= 1'b1;
    bist_addr <= a;
    bist_wdata <= d;
    @(posedge pclk);
    bist_wr_en <= 1'b0;
    bist_addr <= ~a;
    bist_wdata <= ~d;
  endtask : wr
  task automatic rd(logic [AW-1:0] a, output logic [2:0][W-1:0] q);
    @(posedge pclk);
    bist_rd_en <= 1'b1;
    bist_addr <= a;
    @(posedge pclk);
    bist_rd_en <= 1'b0;
    bist_addr <= ~a;
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      q[k] = bist_rdata;
    end
  endtask : rd
  task automatic close();
    @(posedge pclk);
    bist_req <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : close
endmodule : tes_bist_model

// ===== testbench/tes_sideband_test.sv
/* self-checking bench of the sideband block.
   assumes the self-test model and the bound checker. */
`timescale 1ns/10ps
module tes_sideband_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] stb;
  logic rd_access, wr_access, rd_refill, wr_refill;
  logic rd_access_secure, wr_access_secure, rd_refill_secure, wr_refill_secure;
  logic secure_count_en, coherent_walk_tie, test_mode, normalize_tie;
  logic coherent_walk, test_mode_active, normalize_attr;
  logic bist_req, bist_ack, bist_rd_en, bist_wr_en;
  logic [3:0] bist_addr;
  logic [51:0] bist_wdata, bist_rdata;
  logic [2:0][51:0] q;
  logic tick_event, tick_div_event, wr_access_event, rd_access_event;
  logic wr_refill_event, rd_refill_event, e;
  logic [31:0] d;
  int n_errors, num_checks, t;
  assign {wr_refill_secure, rd_refill_secure, wr_access_secure, rd_access_secure,
          wr_refill, rd_refill, wr_access, rd_access} = stb;
  tes_sideband dut_u (.*);
  tes_bist_model bist_u (.*);
  // ---------------------------------------------------------------
  // clock, compares, bus cycles
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk_val(string nm, logic [63:0] ex, logic [63:0] g);
    num_checks++;
    if (g !== ex) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk_val
  task automatic chk_bit(string nm, logic ex, logic g);
    chk_val(nm, {63'h0, ex}, {63'h0, g});
  endtask : chk_bit
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {20'h00000, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    chk_bit("pready", 1'b1, pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(logic [11:0] a, logic [31:0] ex, logic ex_err);
    apb(1'b0, a, 32'h0, d, e);
    chk_val("prdata", {32'h0, ex}, {32'h0, d});
    chk_bit("pslverr", ex_err, e);
  endtask : rd_chk
  task automatic pulse(logic [7:0] v, logic [3:0] ex);
    @(posedge pclk);
    stb <= v;
    @(posedge pclk);
    stb <= 8'h00;
    #1;
    chk_val("events", {60'h0, ex},
            {60'h0, wr_refill_event, rd_refill_event, wr_access_event, rd_access_event});
  endtask : pulse
  task automatic end_of_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #2000000;
    n_errors++;
    end_of_test();
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, stb} = '0;
    {secure_count_en, test_mode} = 2'h0;
    {coherent_walk_tie, normalize_tie, pstrb} = 6'h3f;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    chk_bit("coherent_walk", 1'b1, coherent_walk);
    chk_bit("normalize_attr", 1'b1, normalize_attr);
    rd_chk(tes_pkg::AUX_CFG_OFS, 32'h3, 1'b0);
    rd_chk(tes_pkg::STATUS_OFS, 32'h11, 1'b0);
    rd_chk(12'h010, 32'h0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      pulse(8'h01 << k, 4'h1 << k);
      pulse(8'h11 << k, 4'h0);
    end
    @(posedge pclk);
    secure_count_en <= 1'b1;
    repeat (4) @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      pulse(8'h11 << k, 4'h1 << k);
    end
    rd_chk(tes_pkg::STATUS_OFS, 32'h15, 1'b0);
    rd_chk(tes_pkg::EV_TOTAL_OFS, 32'h8, 1'b0);
    apb(1'b1, tes_pkg::EV_TOTAL_OFS, 32'h0, d, e);
    rd_chk(tes_pkg::EV_TOTAL_OFS, 32'h0, 1'b0);
    t = 0;
    do begin
      @(posedge pclk);
      #1;
      t++;
    end while (tick_div_event !== 1'b1 && t < 70);
    t = 0;
    do begin
      @(posedge pclk);
      #1;
      t++;
    end while (tick_div_event !== 1'b1 && t < 70);
    chk_val("div_period", 64'd64, 64'(t));
    chk_bit("tick_event", 1'b1, tick_event);
    @(posedge pclk);
    test_mode <= 1'b1;
    repeat (5) @(posedge pclk);
    #1;
    chk_bit("test_mode_active", 1'b1, test_mode_active);
    chk_bit("tick_event", 1'b0, tick_event);
    pulse(8'h01, 4'h0);
    @(posedge pclk);
    test_mode <= 1'b0;
    repeat (5) @(posedge pclk);
    #1;
    chk_bit("tick_event", 1'b1, tick_event);
    bist_u.open();
    #1;
    chk_bit("bist_ack", 1'b1, bist_ack);
    rd_chk(tes_pkg::STATUS_OFS, 32'h1d, 1'b0);
    bist_u.wr(4'h0, 52'h5_a5a5_0f0f_1234);
    bist_u.wr(4'hf, 52'ha_5a5a_f0f0_edcb);
    bist_u.rd(4'h0, q);
    for (int j = 0; j < 3; j++) begin
      chk_val("bist_rdata", 64'h5_a5a5_0f0f_1234, 64'(q[j]));
    end
    bist_u.rd(4'hf, q);
    for (int j = 0; j < 3; j++) begin
      chk_val("bist_rdata", 64'ha_5a5a_f0f0_edcb, 64'(q[j]));
    end
    bist_u.close();
    chk_bit("bist_ack", 1'b0, bist_ack);
    // event enable off holds every event low
    apb(1'b1, tes_pkg::AUX_CFG_OFS, 32'h0, d, e);
    #1;
    chk_bit("normalize_attr", 1'b0, normalize_attr);
    pulse(8'h01, 4'h0);
    chk_bit("tick_event", 1'b0, tick_event);
    rd_chk(tes_pkg::AUX_CFG_OFS, 32'h0, 1'b0);
    // second reset captures the other tie levels
    @(posedge pclk);
    presetn <= 1'b0;
    {coherent_walk_tie, normalize_tie} <= 2'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    chk_bit("coherent_walk", 1'b0, coherent_walk);
    chk_bit("normalize_attr", 1'b0, normalize_attr);
    rd_chk(tes_pkg::STATUS_OFS, 32'h14, 1'b0);
    rd_chk(tes_pkg::AUX_CFG_OFS, 32'h2, 1'b0);
    end_of_test();
  end
endmodule : tes_sideband_test
